// *** core/vqsw_pkg.sv ***
// Shared constants and types for the descriptor-switching datapath.
package vqsw_pkg;
    localparam int VQSW_PORTS = 8;
    localparam int VQSW_PORT_W = 3;
    localparam int VQSW_ADDR_W = 5;
    localparam int VQSW_CHIP_W = 2;
    localparam int VQSW_MIN_SOP_BYTES = 64;
    localparam int VQSW_MAX_SOP_BYTES = 384;
    localparam int VQSW_LEN_W = 9;
    localparam int VQSW_FIFO_DEPTH = 32;
    localparam logic [VQSW_CHIP_W-1:0] VQSW_LOCAL_CHIP_RST = 2'h0;
    localparam logic [7:0] VQSW_REFCNT_RST = 8'h00;
    typedef logic [VQSW_PORTS-1:0] vqsw_pmask_t;
    typedef struct packed {
        logic [VQSW_ADDR_W-1:0] addr;
        logic [VQSW_PORT_W-1:0] dest;
        logic mcast;
    } vqsw_desc_t;
    localparam int VQSW_DESC_W = VQSW_ADDR_W + VQSW_PORT_W + 1;
endpackage

// *** core/vqsw_fifo_if.sv ***
// Valid/ready carrier between the switch core and its descriptor queue.
`timescale 1ns/1ps
interface vqsw_fifo_if #(parameter int WIDTH = 9);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// *** core/vqsw_fifo.sv ***
// Parameterised first-in first-out queue with registered read data.
`timescale 1ns/1ps
module vqsw_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    vqsw_fifo_if.fifo q
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [WIDTH-1:0] dout_q;
    logic dval_q;
    wire push = q.in_valid && q.in_ready;
    wire mem_has = (cnt_q != '0);
    wire take = q.out_ready || !dval_q;
    wire pop = mem_has && take;
    assign q.in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign q.out_valid = dval_q;
    assign q.out_data = dout_q;
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_q] <= q.in_data;
        end
    end
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            dout_q <= '0;
            dval_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
                dout_q <= mem[rd_q];
            end
            if (take) begin
                dval_q <= mem_has;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vqsw_fifo

// *** core/vqsw_switch.sv ***
// Descriptor switch: classify, buffer, queue in one shared queue, credit and transmit.
// Contract
// - Start fragment of 64 to 384 bytes goes to ingress header processor.
// - Other fragments bypass the processor into the shared packet buffer.
// - Storing a packet creates exactly one packet descriptor for it.
// - Unicast descriptors enqueue into the queue of their destination port; here all ports share one queue.
// - Scheduler requests credit from destination output queue before forwarding.
// - A descriptor leaves its queue only after credit is granted.
// - Crossbar writes each unicast descriptor into its destination output queue.
// - Output queue schedules descriptors; buffer reads packet to egress processor.
// - Egress processor edits only start-of-packet elements before transmit.
// - Remote credit requests travel through fabric slice to remote output queue.
// - After remote grant, descriptor goes through fabric crossbar to remote queue.
// - Ingress replicator makes copies, each copy one enqueue.
// - Replicated copies go into queues of their own destination ports.
// - Multicast from crossbar goes to egress replicator, copies to output queues; here there is no egress replicator, multicast is copied at ingress only.
// - Each port maps to one of four chips and one of two slices.
`timescale 1ns/1ps
module vqsw_switch #(
    parameter int PORTS = vqsw_pkg::VQSW_PORTS,
    parameter int DEPTH = vqsw_pkg::VQSW_FIFO_DEPTH
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic frag_valid_in,
    input wire logic frag_sop_in,
    input wire logic [vqsw_pkg::VQSW_LEN_W-1:0] frag_len_in,
    input wire logic [7:0] frag_hdr_in,
    input wire logic frag_mcast_in,
    input wire vqsw_pkg::vqsw_pmask_t frag_mcast_mask_in,
    output logic frag_ready_out,
    output logic frag_drop_out,
    input wire logic [vqsw_pkg::VQSW_PORT_W-1:0] proc_dest_in,
    output logic [7:0] proc_hdr_out,
    output logic proc_valid_out,
    output logic [vqsw_pkg::VQSW_PORT_W-1:0] credit_req_port_out,
    output logic credit_req_valid_out,
    output logic credit_req_remote_out,
    output logic [vqsw_pkg::VQSW_CHIP_W-1:0] credit_req_chip_out,
    input wire logic credit_grant_in,
    output logic fabric_desc_valid_out,
    output vqsw_pkg::vqsw_desc_t fabric_desc_out,
    input wire logic fabric_desc_valid_in,
    input wire vqsw_pkg::vqsw_desc_t fabric_desc_in,
    input wire logic [vqsw_pkg::VQSW_CHIP_W-1:0] local_chip_in,
    input wire logic [vqsw_pkg::VQSW_CHIP_W*vqsw_pkg::VQSW_PORTS-1:0] port_chip_map_in,
    input wire vqsw_pkg::vqsw_pmask_t port_slice_map_in,
    output logic tx_valid_out,
    output logic [vqsw_pkg::VQSW_PORT_W-1:0] tx_port_out,
    output logic [vqsw_pkg::VQSW_ADDR_W-1:0] tx_addr_out,
    output logic tx_slice_out,
    output logic tx_edit_sop_out
);
    import vqsw_pkg::*;

    function automatic logic [VQSW_CHIP_W-1:0] chip_of(input logic [VQSW_PORT_W-1:0] p,
            input logic [VQSW_CHIP_W*VQSW_PORTS-1:0] m);
        chip_of = m[p*VQSW_CHIP_W +: VQSW_CHIP_W];
    endfunction

    // Ingress: the start fragment is size-checked and handed to the header processor.
    wire sop_ok = (frag_len_in >= VQSW_LEN_W'(VQSW_MIN_SOP_BYTES))
        && (frag_len_in <= VQSW_LEN_W'(VQSW_MAX_SOP_BYTES));
    logic [VQSW_ADDR_W-1:0] wr_addr_q;
    logic [7:0] refcnt_q [2**VQSW_ADDR_W];
    wire [VQSW_ADDR_W-1:0] next_addr = wr_addr_q + 1'b1;
    wire buf_free = (refcnt_q[wr_addr_q] == VQSW_REFCNT_RST);
    logic proc_valid_q;
    logic [7:0] proc_hdr_q;
    logic drop_q;
    assign proc_valid_out = proc_valid_q;
    assign proc_hdr_out = proc_hdr_q;
    assign frag_drop_out = drop_q;

    // Descriptor queue (shared virtual output queue, kept in arrival order).
    vqsw_fifo_if #(.WIDTH(VQSW_DESC_W)) voq ();
    vqsw_fifo #(.WIDTH(VQSW_DESC_W), .DEPTH(DEPTH)) u_voq (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .q(voq.fifo)
    );

    // Ingress replication walks the multicast mask one port per cycle.
    vqsw_pmask_t rep_mask_q;
    logic [VQSW_ADDR_W-1:0] rep_addr_q;
    logic [VQSW_PORT_W-1:0] rep_port;
    always_comb begin
        rep_port = '0;
        for (int i = PORTS - 1; i >= 0; i--) begin
            if (rep_mask_q[i]) begin
                rep_port = VQSW_PORT_W'(i);
            end
        end
    end
    wire rep_busy = (rep_mask_q != '0);
    wire uni_new = frag_valid_in && frag_sop_in && sop_ok && !frag_mcast_in && !rep_busy;
    wire mc_new = frag_valid_in && frag_sop_in && sop_ok && frag_mcast_in && !rep_busy
        && (frag_mcast_mask_in != '0);
    wire new_pkt = (uni_new || mc_new) && buf_free;
    // Ready only when the start fragment can be stored and queued this cycle.
    wire accept = frag_valid_in && (!frag_sop_in || !sop_ok || (new_pkt && voq.in_ready));
    assign frag_ready_out = !rep_busy && voq.in_ready && buf_free;

    vqsw_desc_t enq_desc;
    assign enq_desc.addr = rep_busy ? rep_addr_q : wr_addr_q;
    assign enq_desc.dest = rep_busy ? rep_port : proc_dest_in;
    assign enq_desc.mcast = 1'b0;
    assign voq.in_valid = rep_busy || (uni_new && buf_free);
    assign voq.in_data = enq_desc;
    wire enq_fire = voq.in_valid && voq.in_ready;
    wire [7:0] mc_copies = 8'($countones(frag_mcast_mask_in));

    // Credit handshake: one outstanding request for the head descriptor.
    vqsw_desc_t head;
    assign head = voq.out_data;
    wire head_remote = (chip_of(head.dest, port_chip_map_in) != local_chip_in);
    logic req_q;
    wire grant = req_q && credit_grant_in;
    assign voq.out_ready = grant;
    assign credit_req_valid_out = req_q;

    // Egress side: local crossbar or fabric input writes the output queue.
    logic oq_valid_q;
    vqsw_desc_t oq_q;
    wire local_xbar = grant && !head_remote;
    wire fab_in = fabric_desc_valid_in && !local_xbar;
    logic fab_pend_q;
    vqsw_desc_t fab_hold_q;
    wire xbar_valid = local_xbar || fab_in || fab_pend_q;
    vqsw_desc_t xbar_desc;
    assign xbar_desc = local_xbar ? head : (fab_pend_q ? fab_hold_q : fabric_desc_in);
    // Local copies free their slot on transmit, remote copies when handed to the fabric.
    // Descriptors that arrive from the fabric point into another chip's buffer, so they
    // must never touch the local counts.
    logic oq_loc_q;
    logic tx_loc_q;
    wire rel_tx = tx_valid_out && tx_loc_q;
    wire rel_fab = fabric_desc_valid_out;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_addr_q <= '0;
            proc_valid_q <= 1'b0;
            proc_hdr_q <= '0;
            drop_q <= 1'b0;
            rep_mask_q <= '0;
            rep_addr_q <= '0;
            for (int i = 0; i < 2**VQSW_ADDR_W; i++) begin
                refcnt_q[i] <= VQSW_REFCNT_RST;
            end
        end else begin
            proc_valid_q <= accept && frag_sop_in && sop_ok;
            proc_hdr_q <= (accept && frag_sop_in) ? frag_hdr_in : proc_hdr_q;
            drop_q <= frag_valid_in && frag_sop_in && !sop_ok;
            if (rep_busy && voq.in_ready) begin
                rep_mask_q <= rep_mask_q & ~(vqsw_pmask_t'(1) << rep_port);
            end
            if (new_pkt && voq.in_ready) begin
                wr_addr_q <= next_addr;
                if (mc_new) begin
                    rep_mask_q <= frag_mcast_mask_in;
                    rep_addr_q <= wr_addr_q;
                end
            end
            // Reference counts: one per queued copy, released on local transmit or fabric
            // hand-off; a take on the same slot wins over its release.
            for (int i = 0; i < 2**VQSW_ADDR_W; i++) begin
                if (new_pkt && voq.in_ready && wr_addr_q == VQSW_ADDR_W'(i)) begin
                    refcnt_q[i] <= mc_new ? mc_copies : 8'h01;
                end else begin
                    refcnt_q[i] <= refcnt_q[i]
                        - 8'(rel_tx && tx_addr_out == VQSW_ADDR_W'(i))
                        - 8'(rel_fab && fabric_desc_out.addr == VQSW_ADDR_W'(i));
                end
            end
        end
    end
    // Non-start fragments are stored directly at the current packet's slot.
    // The payload itself lives outside; only ownership is tracked here.

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_q <= 1'b0;
            credit_req_port_out <= '0;
            credit_req_remote_out <= 1'b0;
            credit_req_chip_out <= VQSW_LOCAL_CHIP_RST;
        end else begin
            req_q <= voq.out_valid && !grant;
            credit_req_port_out <= head.dest;
            credit_req_remote_out <= head_remote;
            credit_req_chip_out <= chip_of(head.dest, port_chip_map_in);
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fabric_desc_valid_out <= 1'b0;
            fabric_desc_out <= '0;
            fab_pend_q <= 1'b0;
            fab_hold_q <= '0;
            oq_valid_q <= 1'b0;
            oq_q <= '0;
            oq_loc_q <= 1'b0;
        end else begin
            oq_loc_q <= local_xbar;
            fabric_desc_valid_out <= grant && head_remote;
            fabric_desc_out <= head;
            fab_pend_q <= fabric_desc_valid_in && local_xbar;
            fab_hold_q <= fabric_desc_in;
            oq_valid_q <= xbar_valid;
            oq_q <= xbar_desc;
        end
    end

    // Output queue schedules to the buffer read; egress edits start elements only.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_valid_out <= 1'b0;
            tx_port_out <= '0;
            tx_addr_out <= '0;
            tx_slice_out <= 1'b0;
            tx_edit_sop_out <= 1'b0;
            tx_loc_q <= 1'b0;
        end else begin
            tx_loc_q <= oq_loc_q;
            tx_valid_out <= oq_valid_q;
            tx_port_out <= oq_q.dest;
            tx_addr_out <= oq_q.addr;
            tx_slice_out <= port_slice_map_in[oq_q.dest];
            tx_edit_sop_out <= oq_valid_q;
        end
    end
endmodule // vqsw_switch

// *** tb/vqsw_switch_assertions.sv ***
// Port-level assertions for the descriptor switch.
`timescale 1ns/1ps
module vqsw_switch_assertions (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic frag_valid_in,
    input wire logic frag_sop_in,
    input wire logic [8:0] frag_len_in,
    input wire logic [7:0] frag_hdr_in,
    input wire logic frag_ready_out,
    input wire logic frag_drop_out,
    input wire logic [7:0] proc_hdr_out,
    input wire logic proc_valid_out,
    input wire logic [2:0] credit_req_port_out,
    input wire logic credit_req_valid_out,
    input wire logic credit_req_remote_out,
    input wire logic [1:0] credit_req_chip_out,
    input wire logic credit_grant_in,
    input wire logic fabric_desc_valid_out,
    input wire logic [1:0] local_chip_in,
    input wire logic [15:0] port_chip_map_in,
    input wire vqsw_pkg::vqsw_pmask_t port_slice_map_in,
    input wire logic tx_valid_out,
    input wire logic [2:0] tx_port_out,
    input wire logic tx_slice_out
);
    import vqsw_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    logic len_ok;
    logic [1:0] req_chip;
    assign len_ok = frag_len_in >= VQSW_MIN_SOP_BYTES && frag_len_in <= VQSW_MAX_SOP_BYTES;
    assign req_chip = port_chip_map_in[{credit_req_port_out, 1'b0} +: 2];
    sequence sop_seen;
        frag_valid_in && frag_sop_in && frag_ready_out;
    endsequence
    sequence grant_seen;
        credit_grant_in && credit_req_valid_out;
    endsequence
    sop_fwd_a: assert property (sop_seen ##0 len_ok |=>
        proc_valid_out && proc_hdr_out == $past(frag_hdr_in)) else $error("sop not forwarded");
    len_drop_a: assert property (sop_seen ##0 !len_ok |=> frag_drop_out && !proc_valid_out)
        else $error("bad length not dropped");
    body_bypass_a: assert property (frag_valid_in && !frag_sop_in |=> !proc_valid_out)
        else $error("body fragment sent to processor");
    req_hold_a: assert property (credit_req_valid_out && !credit_grant_in |=>
        credit_req_valid_out && $stable(credit_req_port_out)) else $error("request dropped");
    grant_tx_a: assert property (grant_seen ##0 !credit_req_remote_out |-> ##[2:3] tx_valid_out)
        else $error("granted descriptor not sent");
    remote_desc_a: assert property (grant_seen ##0 credit_req_remote_out |->
        ##[1:2] fabric_desc_valid_out) else $error("remote descriptor not sent");
    chip_map_a: assert property (credit_req_valid_out |-> credit_req_chip_out == req_chip &&
        credit_req_remote_out == (req_chip != local_chip_in)) else $error("bad chip route");
    slice_map_a: assert property (tx_valid_out |->
        tx_slice_out == port_slice_map_in[tx_port_out]) else $error("bad slice");
endmodule // vqsw_switch_assertions

// *** tb/vqsw_credit_partner.sv ***
// Far-side output queue that grants credit promptly or slowly.
`timescale 1ns/1ps
module vqsw_credit_partner (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic req_valid_in,
    input wire logic [3:0] delay_in,
    output logic grant_out
);
    logic [3:0] wait_q;
    logic [1:0] gap_q;
    // The gap keeps a standing request from being granted twice.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            grant_out <= 1'b0;
            wait_q <= 4'h0;
            gap_q <= 2'h0;
        end else begin
            grant_out <= 1'b0;
            if (gap_q != 2'h0) begin
                gap_q <= gap_q - 2'h1;
            end else if (req_valid_in && wait_q >= delay_in) begin
                grant_out <= 1'b1;
                gap_q <= 2'h3;
                wait_q <= 4'h0;
            end else if (req_valid_in) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // vqsw_credit_partner

// *** tb/tb_vqsw_switch.sv ***
// Self-checking bench for the descriptor switch.
`timescale 1ns/1ps
module tb_vqsw_switch;
    import vqsw_pkg::*;
    logic ref_clk_in = 1'b0, resetn_in = 1'b0, frag_valid_in = 1'b0;
    logic frag_sop_in = 1'b0, frag_mcast_in = 1'b0, fabric_desc_valid_in = 1'b0;
    logic [8:0] frag_len_in = '0;
    logic [7:0] frag_hdr_in = '0, proc_hdr_out;
    vqsw_pmask_t frag_mcast_mask_in = '0, port_slice_map_in = 8'h96;
    logic [2:0] proc_dest_in = '0, credit_req_port_out, tx_port_out;
    logic [1:0] local_chip_in = 2'h0, credit_req_chip_out;
    logic [15:0] port_chip_map_in = 16'h5500;
    vqsw_desc_t fabric_desc_in = '0, fabric_desc_out;
    logic frag_ready_out, frag_drop_out, proc_valid_out, credit_req_valid_out, credit_grant_in;
    logic credit_req_remote_out, tx_valid_out, tx_slice_out, tx_edit_sop_out, fabric_desc_valid_out;
    logic [4:0] tx_addr_out;
    logic [3:0] delay = 4'h0;
    logic [31:0] seed = 32'h062082b6;
    logic [8:0] lens[6] = '{9'h03f, 9'h040, 9'h180, 9'h181, 9'h000, 9'h1ff};
    int n_mismatch = 0, tests_run = 0, exp_drop = 0, got_drop = 0, refused = 0, i;
    logic [3:0] exp_tx[$];
    logic [7:0] exp_hdr[$];
    always #10 ref_clk_in = ~ref_clk_in;
    vqsw_switch vqsw_switch_i (.*);
    vqsw_credit_partner vqsw_credit_partner_i (.ref_clk_in, .resetn_in,
        .req_valid_in(credit_req_valid_out), .delay_in(delay), .grant_out(credit_grant_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Upper bit of an expected entry says the copy leaves through the fabric.
    function automatic logic [3:0] route(input logic [2:0] p);
        return {port_chip_map_in[{p, 1'b0} +: 2] != local_chip_in, p};
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic take(input logic [3:0] got);
        int k;
        k = 0;
        while (k < exp_tx.size() && exp_tx[k] !== got) k++;
        chk(9'(k < exp_tx.size()), 9'h001, "stray descriptor");
        if (k < exp_tx.size()) exp_tx.delete(k);
    endtask
    always @(posedge ref_clk_in) begin
        if (resetn_in) begin
            if (proc_valid_out === 1'b1) chk(9'(proc_hdr_out), 9'(exp_hdr.pop_front()), "hdr");
            if (tx_valid_out === 1'b1) take({1'b0, tx_port_out});
            if (tx_valid_out === 1'b1) chk(9'(tx_edit_sop_out), 9'h001, "sop edit");
            if (fabric_desc_valid_out === 1'b1) take({1'b1, fabric_desc_out.dest});
            if (frag_drop_out === 1'b1) got_drop++;
        end
    end
    task automatic frag(input logic sop, input logic [8:0] len, input logic [2:0] d,
                        input logic [7:0] m);
        int p;
        frag_valid_in = 1'b1;
        frag_sop_in = sop;
        frag_len_in = len;
        frag_hdr_in = 8'(rnd());
        proc_dest_in = d;
        frag_mcast_in = m != 8'h00;
        frag_mcast_mask_in = m;
        if (sop && frag_ready_out !== 1'b1) refused++;
        else if (sop && (len < 9'h040 || len > 9'h180)) exp_drop++;
        else if (sop) begin
            exp_hdr.push_back(frag_hdr_in);
            for (p = 0; p < VQSW_PORTS; p++) if (m[p]) exp_tx.push_back(route(3'(p)));
            if (m == 8'h00) exp_tx.push_back(route(d));
        end
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic pkt(input logic [8:0] len, input logic [2:0] d, input logic [7:0] m);
        frag(1'b1, len, d, m);
        frag(1'b0, 9'h100, d, 8'h00);
        frag(1'b0, 9'h020, d, 8'h00);
    endtask
    task automatic drain(input int limit);
        int k;
        frag_valid_in = 1'b0;
        fabric_desc_valid_in = 1'b0;
        for (k = 0; k < limit && exp_tx.size() != 0; k++) @(posedge ref_clk_in);
        repeat (4) @(posedge ref_clk_in);
        #1 chk(9'(exp_tx.size()), 9'h000, "pending");
        chk(9'(got_drop), 9'(exp_drop), "drops");
        chk(9'(exp_hdr.size()), 9'h000, "headers");
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        #1 resetn_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        foreach (lens[j]) pkt(lens[j], 3'(j), 8'h00);
        drain(300);
        for (i = 0; i < VQSW_PORTS; i++) pkt(9'h080, 3'(i), 8'h00);
        drain(300);
        pkt(9'h100, 3'h0, 8'h0f);
        pkt(9'h0c0, 3'h0, 8'ha5);
        drain(300);
        fabric_desc_in = '{addr: 5'h13, dest: 3'h2, mcast: 1'b0};
        fabric_desc_valid_in = 1'b1;
        exp_tx.push_back(4'h2);
        @(posedge ref_clk_in);
        #1 drain(100);
        delay = 4'hf;
        for (i = 0; i < 40; i++) frag(1'b1, 9'h040, 3'(rnd()), 8'h00);
        chk(9'(refused != 0), 9'h001, "never refused");
        drain(3000);
        delay = 4'h0;
        for (i = 0; i < 30; i++) pkt(9'(rnd() % 321) + 9'h040, 3'(rnd()), 8'(rnd() & rnd()));
        drain(2000);
        end_of_test();
    end
    initial begin
        #400000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule // tb_vqsw_switch
bind vqsw_switch vqsw_switch_assertions vqsw_switch_assertions_i (.*);
